/* hdl/pss_regs.vh */
`ifndef PSS_REGS_VH
`define PSS_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// Register indices; byte address is four times the index
`define PSS_IDX_FCTL    6'h10
`define PSS_IDX_STS     6'h11
`define PSS_IDX_MASK    6'h12
`define PSS_IDX_ISTS    6'h13

////////////////////////////////////////////////////////////////////////////////
// Reset values and writable bits
`define PSS_FCTL_RST    16'h0062
`define PSS_FCTL_WMASK  16'h006F
`define PSS_MASK_RST    16'h0000
`define PSS_IRQ_BITS    16'hFC63
`define PSS_XMODE_RST   2'h3

////////////////////////////////////////////////////////////////////////////////
// Function control fields
`define PSS_FC_XM_HI    6
`define PSS_FC_XM_LO    5
`define PSS_FC_CRS      3
`define PSS_FC_SQE      2
`define PSS_FC_POL      1
`define PSS_FC_JAB      0

////////////////////////////////////////////////////////////////////////////////
// Status fields
`define PSS_ST_SPD_HI   15
`define PSS_ST_SPD_LO   14
`define PSS_ST_DUP      13
`define PSS_ST_PAGE     12
`define PSS_ST_RES      11
`define PSS_ST_LINK     10
`define PSS_ST_MDIX     6
`define PSS_ST_DGRD     5
`define PSS_ST_TXP      3
`define PSS_ST_RXP      2
`define PSS_ST_POL      1
`define PSS_ST_JAB      0

////////////////////////////////////////////////////////////////////////////////
// Interrupt source positions
`define PSS_IR_ANERR    15
`define PSS_IR_SPD      14
`define PSS_IR_DUP      13
`define PSS_IR_PAGE     12
`define PSS_IR_LDN      11
`define PSS_IR_LUP      10
`define PSS_IR_WOL      6
`define PSS_IR_DGRD     5
`define PSS_IR_POL      1
`define PSS_IR_JAB      0

////////////////////////////////////////////////////////////////////////////////
// Encodings
`define PSS_SPD_1000    2'h2
`define PSS_SPD_100     2'h1
`define PSS_SPD_10      2'h0
`define PSS_XM_MDI      2'h0
`define PSS_XM_MDIX     2'h1

`endif

/* hdl/pss_status_build.v */
`timescale 1ns/1ps
`include "pss_regs.vh"

module pss_status_build
(
	// Resolution inputs
	input wire        an_enable,
	input wire        an_done,
	input wire [1:0]  spd_raw,
	input wire        dup_raw,
	input wire        txp_res,
	input wire        rxp_res,
	// Live conditions
	input wire        page_rx,
	input wire        link_up,
	input wire        mdix_raw,
	input wire        dgrd,
	input wire        pol_raw,
	input wire        jab_raw,
	// Configuration
	input wire [1:0]  xmode_act,
	input wire        en_pol,
	input wire        dis_jab,
	// Results
	output reg [15:0] sts,
	output reg        jab_en,
	output reg        pol_force
);

	reg resolved;
	reg is_10m;

	always @*
	begin
		sts = 16'h0000;
		// [R5] resolution done
		resolved = an_enable ? an_done : 1'b1;
		is_10m = resolved && (spd_raw == `PSS_SPD_10);
		// [R1] force normal polarity
		pol_force = is_10m && !en_pol;
		// [R2] jabber 10M half only
		jab_en = is_10m && !dup_raw && !dis_jab;
		sts[`PSS_ST_RES] = resolved;
		// [R3] speed code
		if (resolved)
			sts[`PSS_ST_SPD_HI:`PSS_ST_SPD_LO] = spd_raw;
		// [R4] duplex bit
		sts[`PSS_ST_DUP] = resolved && dup_raw;
		// [R6] live page bit
		sts[`PSS_ST_PAGE] = page_rx;
		// [R7] live link bit
		sts[`PSS_ST_LINK] = link_up;
		// [R8] crossover from mode
		case (xmode_act)
			`PSS_XM_MDI:  sts[`PSS_ST_MDIX] = 1'b0;
			`PSS_XM_MDIX: sts[`PSS_ST_MDIX] = resolved;
			default:      sts[`PSS_ST_MDIX] = resolved && mdix_raw;
		endcase
		sts[`PSS_ST_DGRD] = dgrd;
		// [R9] tx pause, zero when forced
		sts[`PSS_ST_TXP] = an_enable && an_done && txp_res;
		// [R10] rx pause, zero when forced
		sts[`PSS_ST_RXP] = an_enable && an_done && rxp_res;
		// [R11] polarity and jabber live
		sts[`PSS_ST_POL] = pol_raw && !pol_force;
		sts[`PSS_ST_JAB] = jab_raw && jab_en;
	end

endmodule

/* hdl/pss_irq_bank.v */
`timescale 1ns/1ps
`include "pss_regs.vh"

module pss_irq_bank
(
	// Clock and reset
	input wire        mclk,
	input wire        arst_n,
	// Events and control
	input wire [15:0] evt,
	input wire [15:0] mask,
	input wire        clr_we,
	input wire [15:0] clr_data,
	// Results
	output wire [15:0] ists,
	output reg         irq
);

	reg [15:0] ists_reg;
	wire [15:0] ists_next;
	localparam [15:0] IMPL = `PSS_IRQ_BITS;

	genvar i;
	generate
		for (i = 0; i < 16; i = i + 1)
		begin : g_bit
			// [R13] sticky, set beats clear
			// [R15] reserved bits stay zero
			assign ists_next[i] = IMPL[i] &
				(evt[i] | (ists_reg[i] & ~(clr_we & clr_data[i])));
		end
	endgenerate

	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ists_reg <= 16'h0000;
			irq      <= 1'b0;
		end
		else
		begin
			ists_reg <= ists_next;
			// [R14] any unmasked event pending
			irq      <= |(ists_next & mask);
		end
	end

	assign ists = ists_reg;

endmodule

/* hdl/pss_top.v */
// Function
// [R1] Polarity-reversal enable clear forces normal receive polarity at 10 Mb/s.
// [R2] Jabber acts only at 10 Mb/s half duplex; disable bit turns it off.
// [R3] Speed field: 10 = 1000, 01 = 100, 00 = 10 Mb/s; 11 reserved.
// [R4] Duplex bit one for full, zero for half, valid when resolved.
// [R5] Resolved flag set on negotiation done or when speed forced.
// [R6] Page-received status bit follows live condition, no latching.
// [R7] Link status bit follows live link state, no latching.
// [R8] Crossover bit from mode latched at software reset; one means MDIX.
// [R9] Transmit pause reports negotiated result; zero in forced mode.
// [R10] Receive pause reports negotiated result; zero in forced mode.
// [R11] Bit one shows reversed polarity, bit zero shows jabber present.
// [R12] Mask bits enable their sources; all reset to zero.
// [R13] Link-down event recorded in sticky interrupt status bit.
// [R14] Interrupt output high while any recorded event is unmasked.
// [R15] Reserved status and mask bits read zero, ignore writes.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "pss_regs.vh"

module pss_top
(
	// Clock and reset
	input wire         mclk,
	input wire         arst_n,
	// APB slave
	input wire         psel,
	input wire         penable,
	input wire         pwrite,
	input wire [7:0]   paddr,
	input wire [31:0]  pwdata,
	output reg [31:0]  prdata,
	output reg         pready,
	output reg         pslverr,
	// Negotiation and PMA conditions
	input wire         an_enable_i,
	input wire         an_done_i,
	input wire         an_error_i,
	input wire [1:0]   speed_raw_i,
	input wire         duplex_raw_i,
	input wire         tx_pause_res_i,
	input wire         rx_pause_res_i,
	input wire         page_rx_i,
	input wire         link_up_i,
	input wire         mdix_raw_i,
	input wire         downgrade_i,
	input wire         pol_raw_i,
	input wire         jabber_raw_i,
	input wire         wol_i,
	input wire         sw_reset_i,
	// Configuration to the datapath
	output reg [1:0]   xmode_o,
	output reg         crs_on_tx_o,
	output reg         sqe_test_o,
	output reg         pol_force_normal_o,
	output reg         jabber_en_o,
	// Interrupt
	output wire        irq_o
);

	////////////////////////////////////////////////////////////////////////////
	// Address decode

	localparam [2:0] SEL_NONE = 3'h0;
	localparam [2:0] SEL_FCTL = 3'h1;
	localparam [2:0] SEL_STS  = 3'h2;
	localparam [2:0] SEL_MASK = 3'h3;
	localparam [2:0] SEL_ISTS = 3'h4;

	function [2:0] reg_sel;
		input [7:0] a;
		begin
			reg_sel = SEL_NONE;
			if (a[1:0] == 2'h0)
			begin
				case (a[7:2])
					`PSS_IDX_FCTL: reg_sel = SEL_FCTL;
					`PSS_IDX_STS:  reg_sel = SEL_STS;
					`PSS_IDX_MASK: reg_sel = SEL_MASK;
					`PSS_IDX_ISTS: reg_sel = SEL_ISTS;
					default:       reg_sel = SEL_NONE;
				endcase
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Declarations

	localparam [0:0] ST_IDLE = 1'b0;
	localparam [0:0] ST_ACC  = 1'b1;

	reg  [0:0]  bus_st_reg;
	reg  [0:0]  bus_st_next;
	reg  [15:0] fctl_reg;
	reg  [15:0] mask_reg;
	reg  [1:0]  xmode_reg;
	reg  [15:0] sts_reg;
	reg  [15:0] sts_prev_reg;
	reg  [15:0] rd_word;
	reg  [15:0] evt;

	wire [2:0]  sel;
	wire        setup;
	wire        wr_fire;
	wire [15:0] sts_comb;
	wire [15:0] ists;
	wire        jab_en;
	wire        pol_force;

	// Access qualifiers and write strobes
	wire        acc_ph;
	wire        bad_sel;
	wire        fctl_we;
	wire        mask_we;
	wire        ists_clr;

	assign sel      = reg_sel(paddr);
	assign setup    = psel && !penable;
	// Sequencer state qualifies the access so a stray penable cannot write
	assign acc_ph   = (bus_st_reg == ST_ACC);
	// Writes land only on the completing access edge
	assign wr_fire  = psel && penable && pready && acc_ph && pwrite;
	// Unmapped or misaligned addresses are refused
	assign bad_sel  = (sel == SEL_NONE);
	assign fctl_we  = wr_fire && (sel == SEL_FCTL);
	assign mask_we  = wr_fire && (sel == SEL_MASK);
	assign ists_clr = wr_fire && (sel == SEL_ISTS);

	////////////////////////////////////////////////////////////////////////////
	// Bus sequencing: one wait-free access phase per transfer

	always @*
	begin
		bus_st_next = bus_st_reg;
		case (bus_st_reg)
			ST_IDLE:
			begin
				if (setup)
					bus_st_next = ST_ACC;
			end
			ST_ACC:
			begin
				if (setup)
					bus_st_next = ST_ACC;
				else
					bus_st_next = ST_IDLE;
			end
			default:
				bus_st_next = ST_IDLE;
		endcase
	end

	// [R15] reserved bits read zero
	always @*
	begin
		case (sel)
			SEL_FCTL: rd_word = fctl_reg;
			SEL_STS:  rd_word = sts_reg;
			SEL_MASK: rd_word = mask_reg;
			SEL_ISTS: rd_word = ists;
			default:  rd_word = 16'h0000;
		endcase
	end

	// The slave never stretches an access; the sequencer only tracks the phase
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			bus_st_reg <= ST_IDLE;
		else
			bus_st_reg <= bus_st_next;
	end

	// Read data is captured in the setup cycle so prdata is a flop
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			prdata     <= 32'h00000000;
		end
		else
		begin
			if (setup)
			begin
				pready  <= 1'b1;
				pslverr <= bad_sel;
				prdata  <= pwrite ? 32'h00000000 : {16'h0000, rd_word};
			end
			else
			begin
				pready  <= 1'b0;
				pslverr <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Software-written registers

	// [R1] polarity enable stored
	// [R2] jabber disable stored
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			fctl_reg <= `PSS_FCTL_RST;
		else if (fctl_we)
			fctl_reg <= pwdata[15:0] & `PSS_FCTL_WMASK;
	end

	// Mask changes reach irq one edge after the write lands
	// [R12] mask writable sources
	// [R15] reserved mask bits dropped
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			mask_reg <= `PSS_MASK_RST;
		else if (mask_we)
			mask_reg <= pwdata[15:0] & `PSS_IRQ_BITS;
	end

	// A live crossover change would corrupt the link; it waits for soft reset
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			xmode_reg <= `PSS_XMODE_RST;
		// [R8] mode applied at reset
		else if (sw_reset_i)
			xmode_reg <= fctl_reg[`PSS_FC_XM_HI:`PSS_FC_XM_LO];
	end

	////////////////////////////////////////////////////////////////////////////
	// Status resolution

	pss_status_build u_sts
	(
		.an_enable (an_enable_i),
		.an_done   (an_done_i),
		.spd_raw   (speed_raw_i),
		.dup_raw   (duplex_raw_i),
		.txp_res   (tx_pause_res_i),
		.rxp_res   (rx_pause_res_i),
		.page_rx   (page_rx_i),
		.link_up   (link_up_i),
		.mdix_raw  (mdix_raw_i),
		.dgrd      (downgrade_i),
		.pol_raw   (pol_raw_i),
		.jab_raw   (jabber_raw_i),
		.xmode_act (xmode_reg),
		.en_pol    (fctl_reg[`PSS_FC_POL]),
		.dis_jab   (fctl_reg[`PSS_FC_JAB]),
		.sts       (sts_comb),
		.jab_en    (jab_en),
		.pol_force (pol_force)
	);

	// One cycle of latency keeps reads glitch-free; no latching beyond it
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			sts_reg <= 16'h0000;
		else
		begin
			// [R6] page bit tracks input
			// [R7] link bit tracks input
			sts_reg <= sts_comb;
		end
	end

	// Previous sample feeds the edge detectors
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			sts_prev_reg <= 16'h0000;
		else
			sts_prev_reg <= sts_reg;
	end

	////////////////////////////////////////////////////////////////////////////
	// Event detection

	always @*
	begin
		evt = 16'h0000;
		evt[`PSS_IR_ANERR] = an_error_i;
		evt[`PSS_IR_SPD] = sts_reg[`PSS_ST_SPD_HI:`PSS_ST_SPD_LO] !=
			sts_prev_reg[`PSS_ST_SPD_HI:`PSS_ST_SPD_LO];
		evt[`PSS_IR_DUP] = sts_reg[`PSS_ST_DUP] != sts_prev_reg[`PSS_ST_DUP];
		evt[`PSS_IR_PAGE] = sts_reg[`PSS_ST_PAGE] && !sts_prev_reg[`PSS_ST_PAGE];
		// [R13] link falling edge
		evt[`PSS_IR_LDN] = !sts_reg[`PSS_ST_LINK] && sts_prev_reg[`PSS_ST_LINK];
		evt[`PSS_IR_LUP] = sts_reg[`PSS_ST_LINK] && !sts_prev_reg[`PSS_ST_LINK];
		evt[`PSS_IR_WOL] = wol_i;
		evt[`PSS_IR_DGRD] = sts_reg[`PSS_ST_DGRD] && !sts_prev_reg[`PSS_ST_DGRD];
		evt[`PSS_IR_POL] = sts_reg[`PSS_ST_POL] != sts_prev_reg[`PSS_ST_POL];
		evt[`PSS_IR_JAB] = sts_reg[`PSS_ST_JAB] && !sts_prev_reg[`PSS_ST_JAB];
	end

	// Write-one-to-clear on the interrupt status word
	pss_irq_bank u_irq
	(
		.mclk     (mclk),
		.arst_n   (arst_n),
		.evt      (evt),
		.mask     (mask_reg),
		.clr_we   (ists_clr),
		.clr_data (pwdata[15:0]),
		.ists     (ists),
		.irq      (irq_o)
	);

	////////////////////////////////////////////////////////////////////////////
	// Configuration outputs

	// Applied crossover mode goes out one edge after soft reset takes it
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			xmode_o <= `PSS_XMODE_RST;
		else
			xmode_o <= xmode_reg;
	end

	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			crs_on_tx_o        <= 1'b0;
			sqe_test_o         <= 1'b0;
			pol_force_normal_o <= 1'b0;
			jabber_en_o        <= 1'b0;
		end
		else
		begin
			crs_on_tx_o        <= fctl_reg[`PSS_FC_CRS];
			// SQE test never runs in full duplex
			sqe_test_o         <= fctl_reg[`PSS_FC_SQE] && !duplex_raw_i;
			// [R1] polarity forced normal
			pol_force_normal_o <= pol_force;
			// [R2] jabber enable to PMA
			jabber_en_o        <= jab_en;
		end
	end

endmodule

/* testbench/pss_top_assertions.sv */
`timescale 1ns/1ps
module pss_chk
(
	// Clock and reset
	input wire        mclk,
	input wire        arst_n,
	// APB
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	// Conditions
	input wire        an_enable_i,
	input wire        an_done_i,
	input wire [1:0]  speed_raw_i,
	input wire        duplex_raw_i,
	input wire        link_up_i,
	// Datapath
	input wire        pol_force_normal_o,
	input wire        jabber_en_o
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	sequence setup_s;
		psel && !penable;
	endsequence
	// Status is registered, so a read shows inputs from two edges back
	sequence sts_rd_s;
		setup_s ##0 (!pwrite && paddr == 8'h44);
	endsequence
	ready_after_setup_a: assert property (setup_s |=> pready)
		else $error("no ready after setup");
	ready_single_a: assert property (pready |=> !pready)
		else $error("ready held");
	bad_addr_err_a: assert property (setup_s ##0 paddr[1:0] != 2'h0 |=> pslverr)
		else $error("misaligned access not refused");
	upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0000)
		else $error("upper read data not zero");
	link_live_a: assert property (sts_rd_s |=> prdata[10] == $past(link_up_i, 2))
		else $error("link bit not live");
	forced_pause_a: assert property (sts_rd_s ##0 !$past(an_enable_i) |=> prdata[3:2] == 2'h0)
		else $error("pause bits set when forced");
	unres_zero_a: assert property (sts_rd_s ##0 $past(an_enable_i && !an_done_i)
		|=> prdata[15:13] == 3'h0 && !prdata[11] && !prdata[6])
		else $error("unresolved fields not zero");
	jab_mode_a: assert property ((speed_raw_i != 2'h0 && $past(speed_raw_i) != 2'h0)
		|| (duplex_raw_i && $past(duplex_raw_i)) |=> !jabber_en_o)
		else $error("jabber enabled outside ten half");
	pol_speed_a: assert property (speed_raw_i != 2'h0 && $past(speed_raw_i) != 2'h0
		|=> !pol_force_normal_o)
		else $error("polarity forced above ten");
endmodule
bind pss_top pss_chk u_chk (.mclk, .arst_n, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
	.pslverr, .an_enable_i, .an_done_i, .speed_raw_i, .duplex_raw_i, .link_up_i,
	.pol_force_normal_o, .jabber_en_o);

/* testbench/pss_mac_master.sv */
`timescale 1ns/1ps
module pss_mac_master
(
	// Clock
	input wire          mclk,
	// APB request
	output logic        psel,
	output logic        penable,
	output logic        pwrite,
	output logic [7:0]  paddr,
	output logic [31:0] pwdata,
	// APB answer
	input wire [31:0]   prdata,
	input wire          pready,
	input wire          pslverr
);
	initial
	begin
		{psel, penable, pwrite} = 3'h0;
		paddr = 8'hFF;
		pwdata = 32'hFFFFFFFF;
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e, output logic to);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		to = (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		// Released lines invert so a stale value cannot pass
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule

/* testbench/pss_top_tb.sv */
`timescale 1ns/1ps
module pss_top_tb;
	logic        mclk, arst_n, an_enable_i, an_done_i, an_error_i, duplex_raw_i;
	logic        tx_pause_res_i, rx_pause_res_i, page_rx_i, link_up_i, mdix_raw_i;
	logic        downgrade_i, pol_raw_i, jabber_raw_i, wol_i, sw_reset_i, re;
	logic [1:0]  speed_raw_i;
	logic [31:0] rv;
	wire         psel, penable, pwrite, pready, pslverr, crs_on_tx_o, sqe_test_o;
	wire         pol_force_normal_o, jabber_en_o, irq_o;
	wire [1:0]   xmode_o;
	wire [7:0]   paddr;
	wire [31:0]  pwdata, prdata;
	int          mismatches, n_compared;
	pss_top dut (.mclk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .an_enable_i, .an_done_i, .an_error_i, .speed_raw_i, .duplex_raw_i,
		.tx_pause_res_i, .rx_pause_res_i, .page_rx_i, .link_up_i, .mdix_raw_i, .downgrade_i,
		.pol_raw_i, .jabber_raw_i, .wol_i, .sw_reset_i, .xmode_o, .crs_on_tx_o, .sqe_test_o,
		.pol_force_normal_o, .jabber_en_o, .irq_o);
	pss_mac_master u_mac (.mclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr);
	////////////////////////////////////////
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e)
		begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		logic to;
		u_mac.xfer(w, a, d, rv, re, to);
		if (to)
		begin
			mismatches++;
			conclude();
		end
	endtask
	task automatic rd(input logic [7:0] a);
		acc(1'b0, a, 32'h0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		acc(1'b1, a, d);
	endtask
	task automatic swr();
		@(posedge mclk);
		sw_reset_i <= 1'b1;
		@(posedge mclk);
		sw_reset_i <= 1'b0;
	endtask
	////////////////////////////////////////
	task automatic t_regs();
		rd(8'h40);
		chk(rv, 32'h62);
		rd(8'h48);
		chk(rv, 32'h0);
		wr(8'h48, 32'hFFFF);
		rd(8'h48);
		chk(rv, 32'hFC63);
		wr(8'h44, 32'hFFFF);
		rd(8'h44);
		chk(rv, 32'h0);
		rd(8'h50);
		chk({31'h0, re}, 32'h1);
		wr(8'h49, 32'h0);
		rd(8'h48);
		chk(rv, 32'hFC63);
		wr(8'h48, 32'h0);
	endtask
	task automatic t_live();
		@(posedge mclk);
		{page_rx_i, link_up_i, downgrade_i} <= 3'h7;
		rd(8'h44);
		chk(rv, 32'h1420);
		@(posedge mclk);
		{page_rx_i, link_up_i, downgrade_i} <= 3'h0;
		rd(8'h44);
		chk(rv, 32'h0);
	endtask
	task automatic t_speed();
		@(posedge mclk);
		{an_enable_i, duplex_raw_i, tx_pause_res_i, rx_pause_res_i} <= 4'h7;
		for (int s = 0; s < 3; s++)
		begin
			@(posedge mclk);
			speed_raw_i <= s[1:0];
			rd(8'h44);
			chk(rv, {16'h0, s[1:0], 14'h2800});
		end
		@(posedge mclk);
		{an_enable_i, an_done_i} <= 2'h3;
		rd(8'h44);
		chk(rv, 32'hA80C);
		@(posedge mclk);
		{an_done_i, speed_raw_i} <= 3'h0;
		rd(8'h44);
		chk(rv, 32'h0);
	endtask
	task automatic t_poljab();
		@(posedge mclk);
		{an_enable_i, duplex_raw_i, pol_raw_i, jabber_raw_i} <= 4'h3;
		rd(8'h44);
		chk(rv, 32'h0803);
		chk({30'h0, jabber_en_o, pol_force_normal_o}, 32'h2);
		wr(8'h40, 32'h61);
		rd(8'h44);
		chk(rv, 32'h0800);
		chk({30'h0, jabber_en_o, pol_force_normal_o}, 32'h1);
		wr(8'h40, 32'h62);
		@(posedge mclk);
		duplex_raw_i <= 1'b1;
		rd(8'h44);
		chk(rv, 32'h2802);
		chk({31'h0, jabber_en_o}, 32'h0);
		@(posedge mclk);
		{duplex_raw_i, pol_raw_i, jabber_raw_i} <= 3'h0;
	endtask
	task automatic t_mdix();
		@(posedge mclk);
		mdix_raw_i <= 1'b1;
		rd(8'h44);
		chk(rv, 32'h0840);
		// Crossover mode must wait for a software reset
		wr(8'h40, 32'h02);
		rd(8'h44);
		chk(rv, 32'h0840);
		swr();
		rd(8'h44);
		chk(rv, 32'h0800);
		chk({30'h0, xmode_o}, 32'h0);
		wr(8'h40, 32'h22);
		mdix_raw_i <= 1'b0;
		swr();
		rd(8'h44);
		chk(rv, 32'h0840);
		// Reserved control bits drop; carrier and SQE bits reach their pins
		wr(8'h40, 32'hFFFF);
		rd(8'h40);
		chk(rv, 32'h6F);
		chk({30'h0, crs_on_tx_o, sqe_test_o}, 32'h3);
	endtask
	task automatic t_irq();
		wr(8'h4C, 32'hFFFF);
		wr(8'h48, 32'h0800);
		@(posedge mclk);
		link_up_i <= 1'b1;
		rd(8'h4C);
		chk({31'h0, irq_o}, 32'h0);
		@(posedge mclk);
		link_up_i <= 1'b0;
		// Status samples the pin one edge later, the event lands one edge after
		@(posedge mclk);
		rd(8'h4C);
		chk(rv & 32'h0C00, 32'h0C00);
		chk({31'h0, irq_o}, 32'h1);
		wr(8'h4C, 32'h0800);
		@(posedge mclk);
		chk({31'h0, irq_o}, 32'h0);
		rd(8'h4C);
		chk(rv & 32'h0C00, 32'h0400);
	endtask
	////////////////////////////////////////
	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial
	begin
		{an_done_i, an_error_i, duplex_raw_i, tx_pause_res_i, rx_pause_res_i, page_rx_i} = 6'h0;
		{link_up_i, mdix_raw_i, downgrade_i, pol_raw_i, jabber_raw_i, wol_i, sw_reset_i} = 7'h0;
		speed_raw_i = 2'h0;
		an_enable_i = 1'b1;
		arst_n = 1'b0;
		repeat (12) @(posedge mclk);
		arst_n <= 1'b1;
		t_regs();
		t_live();
		t_speed();
		t_poljab();
		t_mdix();
		t_irq();
		conclude();
	end
endmodule
